/* File: verilog/ssx_defines.vh */
// Constants for the subtract, swap and power-down execute block
`ifndef SSX_DEFINES_VH
`define SSX_DEFINES_VH
`define SSX_APB_CTRL      12'h000
`define SSX_APB_INSN      12'h004
`define SSX_APB_ACC       12'h008
`define SSX_APB_STATUS    12'h00C
`define SSX_APB_FILE_DATA 12'h010
`define SSX_APB_FILE_ADDR 12'h014
`define SSX_APB_WDT       12'h018
`define SSX_CTRL_EXEC     0
`define SSX_ST_CARRY      0
`define SSX_ST_NIBBLE     1
`define SSX_ST_ZERO       2
`define SSX_ST_PD         3
`define SSX_ST_TO         4
`define SSX_ST_SLEEP      5
`define SSX_ST_BUSY       6
`define SSX_ST_RESET      8'h18
`define SSX_OP_LIT_HI     5'h1E
`define SSX_OP_SUBF       6'h02
`define SSX_OP_SWAP       6'h0E
`define SSX_OP_SLEEP      14'h0063
`define SSX_FILE_DEPTH    128
`endif

/* File: verilog/ssx_alu.v */
// Subtract and nibble-exchange datapath
`timescale 1ns/10ps
`include "ssx_defines.vh"
module ssx_alu #(
	parameter WIDTH = 8
) (
	input  wire [WIDTH-1:0] i_minuend,
	input  wire [WIDTH-1:0] i_subtrahend,
	output wire [WIDTH-1:0] o_difference,
	output wire [WIDTH-1:0] o_swapped,
	output wire             o_carry,
	output wire             o_nibble_borrow_flag,
	output wire             o_zero
);
	wire [WIDTH:0] full_sum;
	wire [4:0]     low_sum;
	// Two's complement: a + ~b + 1, carry out means no borrow
	assign full_sum = {1'b0, i_minuend} + {1'b0, ~i_subtrahend} + {{WIDTH{1'b0}}, 1'b1};
	assign low_sum  = {1'b0, i_minuend[3:0]} + {1'b0, ~i_subtrahend[3:0]} + 5'h01;
	assign o_difference         = full_sum[WIDTH-1:0];
	assign o_carry              = full_sum[WIDTH];
	assign o_nibble_borrow_flag = low_sum[4];
	assign o_zero               = (full_sum[WIDTH-1:0] == {WIDTH{1'b0}});
	assign o_swapped            = {i_minuend[3:0], i_minuend[7:4]};
endmodule // ssx_alu

/* File: verilog/ssx_exec.v */
// Subtract, swap and power-down execute unit with APB registers
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
`include "ssx_defines.vh"
module ssx_exec #(
	parameter WDT_WIDTH = 8
) (
	input  wire        i_core_clk,
	input  wire        i_reset_n,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	input  wire [3:0]  i_pstrb,
	output reg  [31:0] o_prdata,
	output wire        o_pready,
	output wire        o_pslverr,
	output wire        o_sleep,
	output wire [1:0]  o_q_phase
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	reg  [7:0]           file_mem [0:`SSX_FILE_DEPTH-1];
	reg  [13:0]          insn_q;
	reg  [7:0]           acc_q;
	reg  [7:0]           status_q;
	reg  [6:0]           faddr_q;
	reg  [WDT_WIDTH-1:0] wdt_q;
	reg  [WDT_WIDTH-1:0] wdt_pre_q;
	reg  [1:0]           q_q;
	reg                  state_q;
	reg                  sleep_q;
	reg  [7:0]           operand_q;
	reg  [7:0]           result_q;
	reg                  carry_q;
	reg                  nib_q;
	reg                  zero_q;

	wire wr_acc;
	wire rd_acc;
	wire is_lit;
	wire is_subf;
	wire is_swap;
	wire is_sleep;
	wire dest_file;
	wire [6:0] f_addr;
	wire [7:0] alu_min;
	wire [7:0] diff;
	wire [7:0] swapped;
	wire       c_out;
	wire       n_out;
	wire       z_out;
	wire       exec_go;

	assign wr_acc    = i_psel & i_penable & i_pwrite;
	assign rd_acc    = i_psel & i_penable & ~i_pwrite;
	assign o_pready  = 1'b1;
	assign o_pslverr = 1'b0;
	assign o_sleep   = sleep_q;
	assign o_q_phase = q_q;

	assign is_lit    = (insn_q[13:9] == `SSX_OP_LIT_HI);
	assign is_subf   = ({insn_q[13:12], insn_q[11:8]} == `SSX_OP_SUBF);
	assign is_swap   = ({insn_q[13:12], insn_q[11:8]} == `SSX_OP_SWAP);
	assign is_sleep  = (insn_q == `SSX_OP_SLEEP);
	assign dest_file = insn_q[7];
	assign f_addr    = insn_q[6:0];
	assign exec_go   = wr_acc && (i_paddr == `SSX_APB_CTRL) && i_pwdata[`SSX_CTRL_EXEC]
		&& state_q == ST_IDLE && !sleep_q;

	// Literal minuend spans full 0..255
	assign alu_min = is_lit ? insn_q[7:0] : operand_q;

	ssx_alu #(
		.WIDTH(8)
	) u_alu (
		.i_minuend            (alu_min),
		.i_subtrahend         (acc_q),
		.o_difference         (diff),
		.o_swapped            (swapped),
		.o_carry              (c_out),
		.o_nibble_borrow_flag (n_out),
		.o_zero               (z_out)
	);

	// Four quarter-cycle sequencer, one instruction cycle per op
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q   <= ST_IDLE;
			q_q       <= 2'h0;
			acc_q     <= 8'h00;
			status_q  <= `SSX_ST_RESET;
			insn_q    <= 14'h0000;
			faddr_q   <= 7'h00;
			wdt_q     <= {WDT_WIDTH{1'b0}};
			wdt_pre_q <= {WDT_WIDTH{1'b0}};
			sleep_q   <= 1'b0;
			operand_q <= 8'h00;
			result_q  <= 8'h00;
			carry_q   <= 1'b0;
			nib_q     <= 1'b0;
			zero_q    <= 1'b0;
		end else begin
			if (wr_acc && i_paddr == `SSX_APB_INSN && state_q == ST_IDLE) begin
				insn_q <= i_pwdata[13:0];
			end
			if (wr_acc && i_paddr == `SSX_APB_FILE_ADDR) begin
				faddr_q <= i_pwdata[6:0];
			end
			if (wr_acc && i_paddr == `SSX_APB_STATUS && state_q == ST_IDLE) begin
				status_q <= i_pwdata[7:0];
				// Software may only wake the core; sleep entry stays at Q4
				if (!i_pwdata[`SSX_ST_SLEEP]) begin
					sleep_q <= 1'b0;
				end
			end
			if (wr_acc && i_paddr == `SSX_APB_ACC && state_q == ST_IDLE) begin
				acc_q <= i_pwdata[7:0];
			end
			if (!sleep_q && state_q == ST_IDLE) begin
				wdt_pre_q <= wdt_pre_q + {{(WDT_WIDTH-1){1'b0}}, 1'b1};
				if (&wdt_pre_q) begin
					wdt_q <= wdt_q + {{(WDT_WIDTH-1){1'b0}}, 1'b1};
				end
			end
			case (state_q)
				ST_IDLE: begin
					if (exec_go) begin
						state_q <= ST_RUN;
						q_q     <= 2'h0;
					end
				end
				ST_RUN: begin
					q_q <= q_q + 2'h1;
					case (q_q)
						2'h0: begin
							// File operand read; sleep idles through Q2/Q3
							operand_q <= file_mem[f_addr];
						end
						2'h1: begin
							result_q <= is_swap ? swapped : diff;
							carry_q  <= c_out;
							nib_q    <= n_out;
							zero_q   <= z_out;
						end
						2'h2: begin
						end
						default: begin
							state_q <= ST_IDLE;
							if (is_sleep) begin
								sleep_q              <= 1'b1;
								wdt_q                <= {WDT_WIDTH{1'b0}};
								wdt_pre_q            <= {WDT_WIDTH{1'b0}};
								status_q[`SSX_ST_TO] <= 1'b1;
								status_q[`SSX_ST_PD] <= 1'b0;
							end
							if (is_lit || is_subf) begin
								// Carry, nibble borrow and zero flags from the subtraction
								status_q[`SSX_ST_CARRY]  <= carry_q;
								status_q[`SSX_ST_NIBBLE] <= nib_q;
								status_q[`SSX_ST_ZERO]   <= zero_q;
							end
							if (is_lit || ((is_subf || is_swap) && !dest_file)) begin
								acc_q <= result_q;
							end
						end
					endcase
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// File register array, Q4 write-back or bus write
	always @(posedge i_core_clk) begin
		if (state_q == ST_RUN && q_q == 2'h3 && (is_subf || is_swap) && dest_file) begin
			file_mem[f_addr] <= result_q;
		end else if (wr_acc && i_paddr == `SSX_APB_FILE_DATA && state_q == ST_IDLE) begin
			file_mem[faddr_q] <= i_pwdata[7:0];
		end
	end

	always @* begin
		o_prdata = 32'h0000_0000;
		if (rd_acc) begin
			case (i_paddr)
				`SSX_APB_CTRL:      o_prdata = {31'h0000_0000, state_q};
				`SSX_APB_INSN:      o_prdata = {18'h0_0000, insn_q};
				`SSX_APB_ACC:       o_prdata = {24'h00_0000, acc_q};
				`SSX_APB_STATUS:    o_prdata = {24'h00_0000, status_q[7], state_q,
					sleep_q, status_q[4:0]};
				`SSX_APB_FILE_DATA: o_prdata = {24'h00_0000, file_mem[faddr_q]};
				`SSX_APB_FILE_ADDR: o_prdata = {25'h000_0000, faddr_q};
				`SSX_APB_WDT:       o_prdata = {{(32-WDT_WIDTH){1'b0}}, wdt_q};
				default:            o_prdata = 32'h0000_0000;
			endcase
		end
	end
endmodule // ssx_exec

/* File: verif/ssx_exec_properties.sv */
// Port assertions for the execute unit
`timescale 1ns/10ps
module ssx_exec_properties #(
	parameter WDT_WIDTH = 8
) (
	input wire        i_core_clk,
	input wire        i_reset_n,
	input wire        i_psel,
	input wire        i_penable,
	input wire        i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire [31:0] o_prdata,
	input wire        o_pready,
	input wire        o_pslverr,
	input wire        o_sleep,
	input wire [1:0]  o_q_phase
);
	wire rd_st = i_psel && i_penable && !i_pwrite && i_paddr == 12'h00c;
	wire rd_wd = i_psel && i_penable && !i_pwrite && i_paddr == 12'h018;
	wire wake  = i_psel && i_penable && i_pwrite && i_paddr == 12'h00c && !i_pwdata[5];
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	phase_read_a: assert property (o_q_phase == 2'd1 |=> o_q_phase == 2'd2)
		else $error("phase 1 not followed by 2");
	phase_process_a: assert property (o_q_phase == 2'd2 |=> o_q_phase == 2'd3)
		else $error("phase 2 not followed by 3");
	phase_wrap_a: assert property (o_q_phase == 2'd3 |=> o_q_phase == 2'd0)
		else $error("phase 3 not followed by 0");
	sleep_entry_a: assert property ($rose(o_sleep) |-> $past(o_q_phase) == 2'd3)
		else $error("sleep entered outside Q4");
	sleep_exit_a: assert property ($fell(o_sleep) |-> $past(wake))
		else $error("sleep left without status write");
	status_sleep_a: assert property (rd_st |-> o_prdata[5] == o_sleep)
		else $error("status sleep bit wrong");
	sleep_flags_a: assert property (rd_st && o_sleep |-> o_prdata[4:3] == 2'b10)
		else $error("timeout or power-down bit wrong");
	wdt_clear_a: assert property (rd_wd && o_sleep |-> o_prdata == 32'h0)
		else $error("watchdog not cleared in sleep");
	bus_answer_a: assert property (i_psel && i_penable |-> o_pready && !o_pslverr)
		else $error("access phase not answered cleanly");
	cover property (o_q_phase == 2'd3);
	cover property ($rose(o_sleep));
	cover property ($fell(o_sleep));
endmodule // ssx_exec_properties
bind ssx_exec ssx_exec_properties #(.WDT_WIDTH(WDT_WIDTH)) i_ssx_exec_properties (.i_core_clk,
	.i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
	.o_pslverr, .o_sleep, .o_q_phase);

/* File: verif/tb_ssx_exec.sv */
// Self-checking bench for the execute unit
`timescale 1ns/10ps
`include "ssx_defines.vh"
module tb_ssx_exec;
	logic        clk = 0;
	logic        rst_n = 0;
	logic        psel = 0;
	logic        pen = 0;
	logic        pwr = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic        pready;
	logic        sleep;
	logic [1:0]  qph;
	logic [31:0] rd, k, w, f, d, r, ea, ef, c, dc, z;
	logic [13:0] ins;
	int          bad_count = 0;
	int          n_tests = 0;
	int          seed = 32'h7a50;
	ssx_exec i_ssx_exec (.i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(), .o_sleep(sleep), .o_q_phase(qph));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1;
		pwr <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		psel <= 0;
		pen <= 0;
	endtask
	// Optional accumulator write lands while busy and must be dropped
	task automatic run(input logic [13:0] op, input logic poke);
		int t;
		t = 0;
		apb(1, `SSX_APB_INSN, op);
		apb(1, `SSX_APB_CTRL, 1);
		if (poke)
			apb(1, `SSX_APB_ACC, 32'h5a);
		do begin
			apb(0, `SSX_APB_CTRL, 0);
			t++;
		end while (rd[0] !== 1'b0 && t < 20);
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial forever #20 clk = ~clk;
	initial begin
		#200000;
		bad_count++;
		end_of_test;
	end
	initial begin
		c = 0;
		dc = 0;
		z = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1;
		apb(0, `SSX_APB_STATUS, 0);
		chk(rd, 32'h18);
		for (int i = 0; i < 24; i++) begin
			k = (i == 0) ? 255 : $random(seed) & 255;
			w = $random(seed) & 255;
			f = (i == 2) ? 127 : $random(seed) & 127;
			d = i & 1;
			if (i == 1)
				k = w;
			apb(1, `SSX_APB_ACC, w);
			apb(1, `SSX_APB_FILE_ADDR, f);
			apb(1, `SSX_APB_FILE_DATA, k);
			r = (k - w) & 255;
			if (i % 3 < 2) begin
				c = k >= w;
				dc = (k & 15) >= (w & 15);
				z = r == 0;
			end
			case (i % 3)
				0: ins = {`SSX_OP_LIT_HI, d[0], k[7:0]};
				1: ins = {`SSX_OP_SUBF, d[0], f[6:0]};
				default: ins = {`SSX_OP_SWAP, d[0], f[6:0]};
			endcase
			if (i % 3 == 2)
				r = {k[3:0], k[7:4]};
			ea = (i % 3 == 0 || d == 0) ? r : w;
			ef = (i % 3 != 0 && d == 1) ? r : k;
			run(ins, i % 3 == 2 && d == 1);
			apb(0, `SSX_APB_ACC, 0);
			chk(rd, ea);
			apb(0, `SSX_APB_FILE_DATA, 0);
			chk(rd, ef);
			apb(0, `SSX_APB_STATUS, 0);
			chk(rd, 32'h18 | z << 2 | dc << 1 | c);
		end
		run(`SSX_OP_SLEEP, 0);
		chk(sleep, 1);
		apb(0, `SSX_APB_STATUS, 0);
		chk(rd, 32'h30 | z << 2 | dc << 1 | c);
		apb(0, `SSX_APB_WDT, 0);
		chk(rd, 0);
		run({`SSX_OP_LIT_HI, 9'h0}, 0);
		apb(0, `SSX_APB_ACC, 0);
		chk(rd, ea);
		apb(1, `SSX_APB_STATUS, 0);
		@(posedge clk);
		chk(sleep, 0);
		end_of_test;
	end
endmodule // tb_ssx_exec
